// file: inc/tss_pkg.sv
// What this block does
// - with fs_data_relation set, frame sync is sampled on rising edge, data on falling.
// - each channel word is programmable from 3 to 16 bits long.
// - up to 128 channels; only enabled channels transfer, disabled ones are ignored.
// - each select register holds 16 bits; bit n enables word n of its block.
// - tx select 1 sends the slot word; 0 floats serial_data_out for the whole slot.
// - rx select 1 captures the slot word into the receive buffer; 0 discards it.
// - one companding type bit per direction applies to every active channel alike.
// - multichannel_enable 1 runs multichannel operation; 0 stops all of it.
// - the one multichannel_enable governs receive and transmit together.
// - packed DMA buffers hold only enabled-channel words, consecutive per frame.
// - unpacked tx buffer holds one word per window channel; rx keeps enabled words at their index.
// - unpacked mode accepts channel-enable changes while the port runs.
// - without DMA, interrupt per received word and per started transmit word.
// - with DMA, interrupt only after a whole block has been transferred.
// - word and DMA transfers share the same per-direction interrupt sources.
// - each DMA word transferred steals exactly one core cycle.
// - rx_frame_sync frames both directions, starts channel 0 and restarts the sequence.
// - window is 8 to 128 channels in steps of 8; field 0 means 8 channels.
//
// Holds constants and carrier types of the multichannel slot selector.
// Assumes one clock domain inside; serial pins arrive asynchronously.
package tss_pkg;

  // ----------------------------------------------------------------
  // select register map on the io port
  // ----------------------------------------------------------------
  localparam int          TSS_SEL_REGS    = 8;
  localparam int          TSS_SEL_WIDTH   = 16;
  localparam logic [3:0]  TSS_TX_SEL_BASE = 4'h0;
  localparam logic [3:0]  TSS_RX_SEL_BASE = 4'h8;
  localparam logic [15:0] TSS_SEL_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // word length, window, companding line-code, buffer-full and reset-release constants
  // ----------------------------------------------------------------
  localparam logic [3:0]  TSS_MIN_LEN_M1  = 4'h2;
  localparam logic [2:0]  TSS_WIN_LOW     = 3'h7;
  localparam logic [7:0]  TSS_ALAW_MASK   = 8'h55;
  localparam logic [7:0]  TSS_MULAW_MASK  = 8'hFF;
  localparam logic [1:0]  TSS_BUF_FULL    = 2'h2;
  localparam logic [1:0]  TSS_RST_STAGES  = 2'h0;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic        we;
    logic [15:0] wdata;
  } tss_io_req_t;

  // loose configuration bits of the port
  typedef struct packed {
    logic       multichannelEnable;
    logic       fsDataRelation;
    logic [3:0] wordLenM1;
    logic [3:0] windowSize;
    logic       txPacked;
    logic       rxPacked;
    logic       txDmaEnable;
    logic       rxDmaEnable;
    logic       compandEnable;
    logic       txCompandingType;
    logic       rxCompandingType;
  } tss_cfg_t;

  // one buffered word with its buffer index
  typedef struct packed {
    logic [6:0]  index;
    logic [15:0] data;
  } tss_word_t;

endpackage : tss_pkg

// file: hdl/tss_slot_select.sv
// Multichannel TDM slot selector of the synchronous serial port.
// Assumes sclk, rx_frame_sync and serial data are asynchronous pins,
// sampled by clk at least four times per serial bit.
`timescale 1ns/10ps
module tss_slot_select (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire tss_pkg::tss_io_req_t ioReq,
  output logic [15:0]            ioRData,
  input  wire tss_pkg::tss_cfg_t cfg,
  input  wire logic              sclkIn,
  input  wire logic              rxFrameSyncIn,
  input  wire logic              serialDataIn,
  output logic                   serialDataOut,
  output logic                   serialDataOutEn,
  output logic                   txFrameSync,
  output logic [6:0]             curChannel,
  input  wire tss_pkg::tss_word_t txWord,
  input  wire logic              txValid,
  output logic                   txReady,
  output logic [6:0]             txSentIndex,
  output tss_pkg::tss_word_t     rxWord,
  output logic                   rxValid,
  input  wire logic              rxReady,
  output logic                   txIrq,
  output logic                   rxIrq,
  output logic                   rxDrop,
  output logic                   txUnderflow,
  output logic                   coreStall
);
  import tss_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        sclkSync;
    logic [2:0]        fsSync;
    logic [2:0]        dinSync;
    logic              sclkLvl;
    logic              fsLvl;
    logic              dinLvl;
    logic              inFrame;
    logic              startPend;
    logic [6:0]        chan;
    logic [3:0]        bitCnt;
    logic [4:0]        slotFalls;
    logic [15:0]       rxShift;
    logic [15:0]       txShift;
    logic [6:0]        txPack;
    logic [6:0]        rxPack;
    logic [7:0][15:0]  txSel;
    logic [7:0][15:0]  rxSel;
    logic [15:0]       ioRData;
    logic [1:0][22:0]  rxBuf;
    logic [1:0]        rxCnt;
    logic              rxWr;
    logic              rxRd;
    logic [1:0][22:0]  txBuf;
    logic [1:0]        txCnt;
    logic              txWr;
    logic              txRd;
    logic              dataOut;
    logic              dataOe;
    logic [6:0]        txSentIndex;
    logic              txIrq;
    logic              rxIrq;
    logic              rxDrop;
    logic              txUnder;
    logic [2:0]        stallCnt;
  } tss_state_t;

  tss_state_t st;
  tss_state_t next_st;
  logic [1:0] rstPipe;
  logic       rstSync_n;

  logic       rise;
  logic       fall;
  logic       fsHit;
  logic       lastBit;
  logic       canStart;
  logic       startNow;
  logic       wordDone;
  logic       frameEnd;
  logic       rxSelHit;
  logic       txSelHit;
  logic       rxPush;
  logic       rxPop;
  logic       txPush;
  logic       txPop;
  logic [3:0] effLen;
  logic [6:0] lastChan;
  logic [6:0] slotChan;
  logic [6:0] slotPack;
  logic [15:0] lenMask;
  logic [15:0] txData;
  logic [15:0] rxData;
  logic [2:0] stallAdd;

  // law-dependent inversion applied to the low byte by the compander
  function automatic logic [15:0] tss_compand(input logic [15:0] w, input logic en, input logic law);
    tss_compand = w;
    if (en)
    begin
      tss_compand[7:0] = w[7:0] ^ (law ? TSS_MULAW_MASK : TSS_ALAW_MASK);
    end
  endfunction : tss_compand

  // level accepted once second and third stages agree
  function automatic logic tss_agree(input logic [2:0] s, input logic prev);
    tss_agree = (s[1] == s[2]) ? s[2] : prev;
  endfunction : tss_agree

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rstPipe <= TSS_RST_STAGES;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_n = rstPipe[1];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // pin sampling, framing, shifting, buffers and register port
  always_comb
  begin
    next_st  = st;
    rise     = 1'b0;
    fall     = 1'b0;
    startNow = 1'b0;
    wordDone = 1'b0;
    frameEnd = 1'b0;
    rxPush   = 1'b0;
    txPop    = 1'b0;
    txData   = 16'h0000;
    rxData   = 16'h0000;
    next_st.txIrq   = 1'b0;
    next_st.rxIrq   = 1'b0;
    next_st.rxDrop  = 1'b0;
    next_st.txUnder = 1'b0;

    // three-stage pin synchronisers with agreement filter
    next_st.sclkSync = {st.sclkSync[1:0], sclkIn};
    next_st.fsSync   = {st.fsSync[1:0], rxFrameSyncIn};
    next_st.dinSync  = {st.dinSync[1:0], serialDataIn};
    next_st.sclkLvl  = tss_agree(st.sclkSync, st.sclkLvl);
    next_st.fsLvl    = tss_agree(st.fsSync, st.fsLvl);
    next_st.dinLvl   = tss_agree(st.dinSync, st.dinLvl);
    rise = next_st.sclkLvl && !st.sclkLvl;
    fall = !next_st.sclkLvl && st.sclkLvl;

    effLen   = (cfg.wordLenM1 < TSS_MIN_LEN_M1) ? TSS_MIN_LEN_M1 : cfg.wordLenM1;
    lenMask  = 16'(17'h1FFFF >> (4'hF - effLen + 5'h1));
    lastChan = {cfg.windowSize, TSS_WIN_LOW};
    // per-channel enable of up to 128
    rxSelHit = st.rxSel[st.chan[6:4]][st.chan[3:0]];

    fsHit    = cfg.multichannelEnable && st.fsLvl && (cfg.fsDataRelation ? rise : fall);
    lastBit  = st.inFrame && (st.bitCnt == effLen) && (st.chan == lastChan);
    canStart = !st.inFrame || lastBit;
    if (fsHit && canStart && !cfg.fsDataRelation)
      next_st.startPend = 1'b1;
    startNow = rise && cfg.multichannelEnable &&
               (st.startPend || (cfg.fsDataRelation && fsHit && canStart));

    slotChan = startNow ? 7'h00 : st.chan;
    slotPack = startNow ? 7'h00 : st.txPack;
    txSelHit = st.txSel[slotChan[6:4]][slotChan[3:0]];

    // handshakes of both buffers
    rxPop  = (st.rxCnt != 2'h0) && rxReady;
    txPush = txValid && (st.txCnt != TSS_BUF_FULL);

    // transmit side works on rising serial clock edges
    if (startNow)
    begin
      next_st.inFrame   = 1'b1;
      next_st.startPend = 1'b0;
      next_st.chan      = 7'h00;
      next_st.bitCnt    = 4'h0;
      next_st.txPack    = 7'h00;
      next_st.rxPack    = 7'h00;
    end
    if (rise && (startNow || st.inFrame))
    begin
      if (startNow || st.bitCnt == 4'h0)
      begin
        // packed pops only enabled slots; unpacked pops every slot
        txPop = (txSelHit || !cfg.txPacked) && (st.txCnt != 2'h0);
        if (txPop)
          txData = st.txBuf[st.txRd][15:0];
        // one law for every active transmit channel
        txData = tss_compand(txData, cfg.compandEnable, cfg.txCompandingType);
        // enabled slot drives, disabled slot floats
        next_st.dataOe  = txSelHit;
        next_st.txShift = txData;
        next_st.dataOut = txData[effLen];
        next_st.slotFalls = 5'h00;
        if (txSelHit)
        begin
          next_st.txSentIndex = cfg.txPacked ? slotPack : slotChan;
          next_st.txPack      = slotPack + 7'h01;
          next_st.txUnder     = !txPop;
          next_st.txIrq       = !cfg.txDmaEnable;
        end
      end
      else
      begin
        next_st.txShift = {st.txShift[14:0], 1'b0};
        next_st.dataOut = st.txShift[effLen - 4'h1];
      end
    end

    // receive side samples on falling serial clock edges
    if (fall && st.inFrame)
    begin
      next_st.rxShift = {st.rxShift[14:0], st.dinLvl};
      next_st.slotFalls = st.slotFalls + 5'h01;
      if (st.bitCnt == effLen)
      begin
        wordDone = 1'b1;
        rxData   = tss_compand(next_st.rxShift & lenMask, cfg.compandEnable, cfg.rxCompandingType);
        // capture enabled slot, discard the rest
        if (rxSelHit)
        begin
          rxPush = (st.rxCnt != TSS_BUF_FULL) || rxPop;
          next_st.rxDrop = !rxPush;
          next_st.rxPack = st.rxPack + 7'h01;
          next_st.rxIrq  = !cfg.rxDmaEnable;
        end
        next_st.bitCnt = 4'h0;
        if (st.chan == lastChan)
        begin
          frameEnd        = 1'b1;
          next_st.inFrame = 1'b0;
          next_st.dataOe  = 1'b0;
          // block interrupt on the same sources
          next_st.rxIrq   = next_st.rxIrq || cfg.rxDmaEnable;
          next_st.txIrq   = next_st.txIrq || cfg.txDmaEnable;
        end
        else
        begin
          next_st.chan = st.chan + 7'h01;
        end
      end
      else
      begin
        next_st.bitCnt = st.bitCnt + 4'h1;
      end
    end

    if (!cfg.multichannelEnable)
    begin
      next_st.inFrame   = 1'b0;
      next_st.startPend = 1'b0;
      next_st.dataOe    = 1'b0;
    end

    // receive buffer, pop and push in one cycle allowed
    if (rxPush)
    begin
      next_st.rxBuf[st.rxWr] = {(cfg.rxPacked ? st.rxPack : st.chan), rxData};
      next_st.rxWr = !st.rxWr;
    end
    if (rxPop)
      next_st.rxRd = !st.rxRd;
    next_st.rxCnt = st.rxCnt + 2'(rxPush) - 2'(rxPop);

    // transmit buffer
    if (txPush)
    begin
      next_st.txBuf[st.txWr] = txWord;
      next_st.txWr = !st.txWr;
    end
    if (txPop)
      next_st.txRd = !st.txRd;
    next_st.txCnt = st.txCnt + 2'(txPush) - 2'(txPop);

    // one stolen core cycle per DMA word
    stallAdd = 3'(rxPop && cfg.rxDmaEnable) + 3'(txPush && cfg.txDmaEnable);
    next_st.stallCnt = st.stallCnt + stallAdd - 3'(st.stallCnt != 3'h0);

    // select registers writable at any time
    if (ioReq.we)
      if (ioReq.addr[3])
        next_st.rxSel[ioReq.addr[2:0]] = ioReq.wdata;
      else
        next_st.txSel[ioReq.addr[2:0]] = ioReq.wdata;
    next_st.ioRData = ioReq.addr[3] ? st.rxSel[ioReq.addr[2:0]] : st.txSel[ioReq.addr[2:0]];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // single register for the whole state
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      st <= '0;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pins, buffers and events from the state register
  assign ioRData         = st.ioRData;
  assign serialDataOut   = st.dataOut;
  assign serialDataOutEn = st.dataOe;
  assign txFrameSync     = st.dataOe;
  assign curChannel      = st.chan;
  assign txReady         = st.txCnt != TSS_BUF_FULL;
  assign txSentIndex     = st.txSentIndex;
  assign rxWord          = tss_word_t'(st.rxBuf[st.rxRd]);
  assign rxValid         = st.rxCnt != 2'h0;
  assign txIrq           = st.txIrq;
  assign rxIrq           = st.rxIrq;
  assign rxDrop          = st.rxDrop;
  assign txUnderflow     = st.txUnder;
  assign coreStall       = st.stallCnt != 3'h0;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  a_out_idle_float: assert property (!st.inFrame |-> !serialDataOutEn)
    else $error("serial out driven outside a frame");
  a_slot_drive_sel: assert property (cfg.multichannelEnable && rise && st.inFrame && st.bitCnt == 4'h0 && !startNow
    |=> serialDataOutEn == $past(txSelHit))
    else $error("slot drive does not follow tx select");
  // disabled slot never grows the buffer
  a_rx_discard_off: assert property (wordDone && !rxSelHit && !rxPop |=> st.rxCnt == $past(st.rxCnt))
    else $error("disabled receive slot stored a word");
  // enabled slot into an empty buffer is stored
  a_rx_capture_on: assert property (wordDone && rxSelHit && st.rxCnt == 2'h0 |=> rxValid)
    else $error("enabled receive slot lost");
  // disabled port stays out of frame
  a_mcm_off_quiet: assert property (!cfg.multichannelEnable |=> !st.inFrame && !serialDataOutEn)
    else $error("frame active with multichannel disabled");
  a_frame_restart: assert property (startNow |=> st.inFrame && st.chan == 7'h00 && st.bitCnt == 4'h0)
    else $error("frame start did not reset channel");
  a_chan_window: assert property (st.inFrame |-> st.chan <= lastChan)
    else $error("channel beyond window");
  a_word_length: assert property (wordDone |-> st.slotFalls == 5'(effLen) && effLen >= TSS_MIN_LEN_M1)
    else $error("word length out of range");
  // DMA receive interrupt only at frame end
  a_dma_block_irq: assert property (cfg.rxDmaEnable && !frameEnd |=> !rxIrq)
    else $error("receive interrupt inside a DMA block");
  // DMA word costs a stolen cycle
  a_dma_stall: assert property (rxPop && cfg.rxDmaEnable |=> coreStall)
    else $error("DMA word without stolen cycle");

  c_frame_start: cover property (startNow);
  c_rx_capture: cover property (rxPush);
  c_tx_slot: cover property (rise && txSelHit && txPop);
  c_back_to_back: cover property (frameEnd ##[1:40] startNow);

endmodule : tss_slot_select

// file: testbench/tss_tdm_partner.sv
// Behavioural model of the other devices on the shared TDM serial bus.
// Assumes the port runs with fs_data_relation set and 8-bit words, 8 channels.
`timescale 1ns/10ps
module tss_tdm_partner (
  output logic      sclk,
  output logic      frameSync,
  output logic      dataLine,
  input  wire logic serialDataOut,
  input  wire logic serialDataOutEn
);
  // ----------------------------------------------------------------
  // captured transmit stream, channel 0 msb in bit 63
  // ----------------------------------------------------------------
  logic [63:0] txBits;
  logic [63:0] txOe;

  // idle bus: clock stands low between frames
  initial
  begin
    sclk      = 1'b0;
    frameSync = 1'b0;
    dataLine  = 1'b0;
  end

  // one multichannel frame of 64 bit slots plus two trailing clocks
  task automatic runFrame(input logic [63:0] rxBits);
    int b;
    begin
      // far side runs multichannel frames too
      // frame sync changes while clock is low
      frameSync = 1'b1;
      #40;
      for (b = 0; b < 66; b++)
      begin
        sclk = 1'b1;
        // released line shows the inverse of its last value
        dataLine = (b < 64) ? rxBits[63-b] : ~dataLine;
        #40 sclk = 1'b0;
        frameSync = 1'b0;
        #39;
        if (b < 64)
        begin
          txBits[63-b] = serialDataOut;
          txOe[63-b]   = serialDataOutEn;
        end
        #1;
      end
      dataLine = ~dataLine;
    end
  endtask : runFrame
endmodule : tss_tdm_partner

// file: testbench/tss_slot_select_test.sv
// Self-checking bench of the multichannel slot selector.
// Assumes the partner model on the serial side and a 125 MHz clk.
`timescale 1ns/10ps
module tss_slot_select_test;
  import tss_pkg::*;
  logic        clk;
  logic        arst_n;
  tss_io_req_t ioReq;
  logic [15:0] ioRData;
  tss_cfg_t    cfg;
  logic        sclk;
  logic        fs;
  logic        sdIn;
  logic        sdOut;
  logic        sdOe;
  tss_word_t   txWord;
  logic        txValid;
  logic        txReady;
  logic [6:0]  txSentIndex;
  tss_word_t   rxWord;
  logic        rxValid;
  logic        rxReady;
  logic        txIrq;
  logic        rxIrq;
  logic        rxDrop;
  logic        txUnderflow;
  logic        coreStall;
  logic        txFs;
  logic [6:0]  curChan;
  int          nFsBad;
  int          failCount;
  int          cmpCount;
  int          nTx;
  int          nRx;
  int          nDrop;
  int          nUnder;
  int          nStall;
  localparam logic [63:0] RX_STREAM = 64'h11965AC30FF033CC;
  localparam logic [63:0] SLOT_MASK = 64'hFF00FF0000000000;

  tss_slot_select DUT (.clk(clk), .arst_n(arst_n), .ioReq(ioReq), .ioRData(ioRData), .cfg(cfg),
    .sclkIn(sclk), .rxFrameSyncIn(fs), .serialDataIn(sdIn), .serialDataOut(sdOut),
    .serialDataOutEn(sdOe), .txFrameSync(txFs), .curChannel(curChan), .txWord(txWord), .txValid(txValid),
    .txReady(txReady), .txSentIndex(txSentIndex), .rxWord(rxWord), .rxValid(rxValid),
    .rxReady(rxReady), .txIrq(txIrq), .rxIrq(rxIrq), .rxDrop(rxDrop),
    .txUnderflow(txUnderflow), .coreStall(coreStall));

  tss_tdm_partner PTR (.sclk(sclk), .frameSync(fs), .dataLine(sdIn), .serialDataOut(sdOut),
    .serialDataOutEn(sdOe));

  // ----------------------------------------------------------------
  // clock and event pulse counters
  // ----------------------------------------------------------------
  always #4 clk = ~clk;

  // count one-clk pulses of the event outputs
  always @(posedge clk)
  begin
    nTx    += (txIrq === 1'b1);
    nRx    += (rxIrq === 1'b1);
    nDrop  += (rxDrop === 1'b1);
    nUnder += (txUnderflow === 1'b1);
    nStall += (coreStall === 1'b1);
    nFsBad += (txFs !== sdOe);
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (failCount == 0 && cmpCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic check(input logic [159:0] got, input logic [159:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic regWrite(input logic [3:0] addr, input logic [15:0] data);
    @(posedge clk) ioReq <= '{addr, 1'b1, data};
    @(posedge clk) ioReq.we <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [3:0] addr, input logic [15:0] exp);
    @(posedge clk) ioReq <= '{addr, 1'b0, 16'h0000};
    @(posedge clk);
    @(negedge clk) check(ioRData, exp);
  endtask : regRead

  task automatic pushTx(input logic [15:0] data);
    @(posedge clk)
    begin
      txWord  <= '{7'h00, data};
      txValid <= 1'b1;
    end
    @(posedge clk) txValid <= 1'b0;
  endtask : pushTx

  // wait a bounded time for a stored word, compare it, pop it
  task automatic popRx(input logic [6:0] idx, input logic [15:0] data);
    int n;
    for (n = 0; n < 50 && rxValid !== 1'b1; n++)
      @(negedge clk);
    if (rxValid !== 1'b1)
    begin
      failCount++;
      $display("wrong value at %0t: no receive word", $time);
      summarize();
    end
    check({rxWord.index, rxWord.data}, {idx, data});
    @(posedge clk) rxReady <= 1'b1;
    @(posedge clk) rxReady <= 1'b0;
    // let the pulse counters see the stall of the last pop
    repeat (2) @(negedge clk);
  endtask : popRx

  task automatic setCfg(input logic multichannel_enable, input logic dma, input logic comp);
    @(posedge clk) cfg <= '{multichannel_enable, 1'b1, 4'h7, 4'h0, 1'b1, 1'b0, dma, dma, comp, 1'b0, 1'b1};
    nTx = 0;
    nRx = 0;
    nDrop = 0;
    nUnder = 0;
    nStall = 0;
  endtask : setCfg

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    ioReq = '0;
    cfg = '0;
    txWord = '0;
    txValid = 1'b0;
    rxReady = 1'b0;
    failCount = 0;
    cmpCount = 0;
    nFsBad = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // all sixteen select registers come out of reset cleared
    for (int k = 0; k < 16; k++)
      regRead(k[3:0], TSS_SEL_RESET);
    regWrite(4'h7, 16'hA5C3);
    regRead(4'h7, 16'hA5C3);
    regWrite(4'hF, 16'h5A3C);
    regRead(4'hF, 16'h5A3C);
    regRead(4'h7, 16'hA5C3);
    // frame 1: word interrupts, packed tx, unpacked rx, no core stalls
    setCfg(1'b1, 1'b0, 1'b0);
    regWrite(4'h0, 16'h0005);
    regWrite(4'h8, 16'h0006);
    pushTx(16'h00A5);
    pushTx(16'h003C);
    @(negedge clk) check(txReady, 1'b0);
    PTR.runFrame(RX_STREAM);
    check(PTR.txOe, SLOT_MASK);
    check(PTR.txBits & SLOT_MASK, 64'hA5003C0000000000);
    check(txSentIndex, 7'h01);
    check(curChan, 7'h07);
    popRx(7'h01, 16'h0096);
    popRx(7'h02, 16'h005A);
    check(rxValid, 1'b0);
    check({nTx, nRx, nDrop, nUnder, nStall}, {32'd2, 32'd2, 32'd0, 32'd0, 32'd0});
    // frame 2: block interrupts, companding, rx select changed while running
    setCfg(1'b1, 1'b1, 1'b1);
    regWrite(4'h8, 16'h000E);
    pushTx(16'h00A5);
    pushTx(16'h003C);
    PTR.runFrame(RX_STREAM);
    check(PTR.txBits & SLOT_MASK, 64'hF000690000000000);
    popRx(7'h01, 16'h0069);
    popRx(7'h02, 16'h00A5);
    check({nTx, nRx, nDrop, nStall}, {32'd1, 32'd1, 32'd1, 32'd4});
    // frame 3: empty tx buffer, all receive slots discarded
    setCfg(1'b1, 1'b0, 1'b0);
    regWrite(4'h8, 16'h0000);
    PTR.runFrame(RX_STREAM);
    check(PTR.txBits & SLOT_MASK, 64'h0);
    check({nUnder, nTx, nRx}, {32'd2, 32'd2, 32'd0});
    check(rxValid, 1'b0);
    // frame 4: multichannel off stops both halves
    setCfg(1'b0, 1'b0, 1'b0);
    regWrite(4'h8, 16'h0006);
    PTR.runFrame(RX_STREAM);
    check(PTR.txOe, 64'h0);
    check({nTx, nRx, nUnder}, {32'd0, 32'd0, 32'd0});
    check(rxValid, 1'b0);
    // frame 5: unpacked tx pops every slot, packed rx numbers by count
    setCfg(1'b1, 1'b0, 1'b0);
    @(posedge clk) {cfg.txPacked, cfg.rxPacked} <= 2'b01;
    pushTx(16'h00A5);
    pushTx(16'h003C);
    PTR.runFrame(RX_STREAM);
    check(PTR.txBits & SLOT_MASK, 64'hA500000000000000);
    check({txSentIndex, nUnder, nTx}, {7'h02, 32'd1, 32'd2});
    popRx(7'h00, 16'h0096);
    popRx(7'h01, 16'h005A);
    check({curChan, nFsBad}, {7'h07, 32'd0});
    summarize();
  end
endmodule : tss_slot_select_test
